/* logic/wdw_top.sv */
// Watchdog with periodic interrupt and cyclic wake-up, with register port
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Operation
// - Oscillator and counter run only while irq enable, reset enable or cyclic check is set.
// - Once reset enable is set, software cannot clear it again.
// - A counter timeout with reset enable set starts a system reset.
// - The reset function is suspended in STOP mode and resumes in RUN mode.
// - Writing one to the restart bit restarts the period; it reads zero, zero does nothing.
// - Reset enable is writable once per reset and its reset reaches the pin only in RUN.
// - A timeout reset is driven on the reset output only in RUN mode.
// - The periodic interrupt, enabled by irq enable, wakes the system only in STOP mode.
// - Irq enable lets the timeout flag interrupt, and the interrupt pin asserts only in STOP.
// - Rate one selects the 10 ms period and rate zero the 20 ms period.
// - The flag sets on timeout; writing one clears it and restarts the period, zero is ignored.
// - The cyclic check bit enables periodic sensing of the Hall and analog inputs.
// - In STOP each cycle powers and senses selected inputs; a one with Hall irq wakes and irqs.
// - Every control register bit reads zero after reset.
// - Writing go-to-stop enters STOP; reset or an interrupt request returns to RUN.
module wdw_top #(
    parameter int OSC_DIV = wdw_pkg::WDW_OSC_DIV_CYC,
    parameter int FAST_TICKS = wdw_pkg::WDW_FAST_TICKS,
    parameter int SLOW_TICKS = wdw_pkg::WDW_SLOW_TICKS,
    parameter int NUM_HALL = 3
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire wdw_pkg::wdw_bus_req_s bus_req_in,
    input wire logic [NUM_HALL-1:0] hall_in,
    input wire logic analog_in,
    output logic [7:0] rd_data_out,
    output logic mcu_reset_out,
    output logic irq_out,
    output logic regulator_on_out,
    output logic hall_power_out
);
    import wdw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Local constants
    localparam logic [7:0] END_FAST = 8'(FAST_TICKS - 1);
    localparam logic [7:0] END_SLOW = 8'(SLOW_TICKS - 1);
    localparam logic [4:0] RST_PULSE = 5'(WDW_RST_PULSE_CYC);
    localparam logic [3:0] SENSE_LEN = 4'(WDW_SENSE_CYC);

    // Address match for a strobe
    function automatic logic hit(input wdw_bus_req_s req, input logic [7:0] a, input logic rd);
        hit = (rd ? req.rd : req.wr) && (req.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    wdw_mode_e mode_r;
    wdw_mode_e mode_nxt;
    logic rate_r;
    logic rate_nxt;
    logic cc_r;
    logic cc_nxt;
    logic ie_r;
    logic ie_nxt;
    logic re_r;
    logic re_nxt;
    logic re_locked_r;
    logic re_locked_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [4:0] rst_cnt_r;
    logic [4:0] rst_cnt_nxt;
    logic [3:0] sense_cnt_r;
    logic [3:0] sense_cnt_nxt;
    logic [1:0] sts_r;
    logic [1:0] sts_nxt;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic mcu_reset_r;
    logic mcu_reset_nxt;
    logic irq_r;
    logic irq_nxt;
    logic reg_on_r;
    logic reg_on_nxt;
    logic hall_pwr_r;
    logic hall_pwr_nxt;

    // Decoded strobes and events
    logic wr_ctl;
    logic wr_sys;
    logic wr_sts;
    logic wr_mask;
    logic wr_cfg;
    logic restart;
    logic osc_run;
    logic tick;
    logic [7:0] end_val;
    logic timeout_ev;
    logic per_ev;
    logic hall_ev;
    logic sense_hit;
    logic pending;
    logic in_stop;
    logic [NUM_HALL-1:0] hall_sync;
    logic analog_sync;
    logic [1:0] ev_set;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for the sensed inputs
    wdw_sync #(
        .WIDTH(NUM_HALL + 1)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .async_in({analog_in, hall_in}),
        .sync_out({analog_sync, hall_sync})
    );

    // Low-rate oscillator, running only while a function is enabled
    wdw_tick #(
        .DIV(OSC_DIV)
    ) u_tick (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .run_in(osc_run),
        .clr_in(restart),
        .tick_out(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strobe decode and timing events
    always_comb begin
        wr_ctl = hit(bus_req_in, WDW_ADDR_CTL, 1'b0);
        wr_sys = hit(bus_req_in, WDW_ADDR_SYS, 1'b0);
        wr_sts = hit(bus_req_in, WDW_ADDR_IRQ_STS, 1'b0);
        wr_mask = hit(bus_req_in, WDW_ADDR_IRQ_MASK, 1'b0);
        wr_cfg = hit(bus_req_in, WDW_ADDR_SENSE_CFG, 1'b0);
        in_stop = (mode_r == WDW_STOP);
        // Restart bit or flag clear both begin a new period
        restart = wr_ctl && (bus_req_in.wdata[WDW_CTL_RESTART] ||
                  bus_req_in.wdata[WDW_CTL_FLAG]);
        osc_run = ie_r || re_r || cc_r;
        end_val = rate_r ? END_FAST : END_SLOW;
        timeout_ev = osc_run && tick && !restart && (cnt_r == end_val);
        per_ev = timeout_ev && ie_r && in_stop;
        sense_hit = (|(hall_sync & cfg_r[NUM_HALL-1:0])) ||
                    (analog_sync && cfg_r[WDW_CFG_ANALOG]);
        hall_ev = in_stop && (sense_cnt_r == 4'h1) && sense_hit &&
                  cfg_r[WDW_CFG_HALL_IE];
        ev_set = 2'h0;
        ev_set[WDW_IRQ_TIMEOUT] = per_ev;
        ev_set[WDW_IRQ_HALL] = hall_ev;
        pending = |(sts_r & mask_r);
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register, counter and flag
    always_comb begin
        rate_nxt = rate_r;
        cc_nxt = cc_r;
        ie_nxt = ie_r;
        re_nxt = re_r;
        re_locked_nxt = re_locked_r;
        cnt_nxt = cnt_r;
        flag_nxt = flag_r;
        if (wr_ctl) begin
            rate_nxt = bus_req_in.wdata[WDW_CTL_RATE];
            cc_nxt = bus_req_in.wdata[WDW_CTL_CC];
            ie_nxt = bus_req_in.wdata[WDW_CTL_IE];
            // Reset enable takes only the first write after reset
            if (!re_locked_r) begin
                re_nxt = bus_req_in.wdata[WDW_CTL_RE];
                re_locked_nxt = 1'b1;
            end
            // Set once, it stays set
            re_nxt = re_nxt || re_r;
            if (bus_req_in.wdata[WDW_CTL_FLAG]) begin
                flag_nxt = 1'b0;
            end
        end
        // A flag clear also restarts, which blocks a timeout in the same cycle
        if (timeout_ev) begin
            flag_nxt = 1'b1;
        end
        // Counter steps on oscillator ticks and wraps at the end value
        if (!osc_run || restart) begin
            cnt_nxt = 8'h00;
        end else if (timeout_ev) begin
            cnt_nxt = 8'h00;
        end else if (tick) begin
            cnt_nxt = cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rate_r <= WDW_CTL_RST_VAL[WDW_CTL_RATE];
            cc_r <= WDW_CTL_RST_VAL[WDW_CTL_CC];
            ie_r <= WDW_CTL_RST_VAL[WDW_CTL_IE];
            re_r <= WDW_CTL_RST_VAL[WDW_CTL_RE];
            flag_r <= WDW_CTL_RST_VAL[WDW_CTL_FLAG];
            re_locked_r <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            rate_r <= rate_nxt;
            cc_r <= cc_nxt;
            ie_r <= ie_nxt;
            re_r <= re_nxt;
            flag_r <= flag_nxt;
            re_locked_r <= re_locked_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog reset pulse toward the microcontroller
    always_comb begin
        rst_cnt_nxt = rst_cnt_r;
        if (timeout_ev && re_r && !in_stop) begin
            rst_cnt_nxt = RST_PULSE;
        end else if (rst_cnt_r != 5'h00) begin
            rst_cnt_nxt = rst_cnt_r - 5'h01;
        end
        // Reset pin only ever driven in RUN
        mcu_reset_nxt = (rst_cnt_nxt != 5'h00) && (mode_nxt == WDW_RUN);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rst_cnt_r <= 5'h00;
            mcu_reset_r <= 1'b0;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            mcu_reset_r <= mcu_reset_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cyclic check: power the sensors for a short window each period
    always_comb begin
        sense_cnt_nxt = sense_cnt_r;
        if (!in_stop || !cc_r) begin
            sense_cnt_nxt = 4'h0;
        end else if (timeout_ev) begin
            sense_cnt_nxt = SENSE_LEN;
        end else if (sense_cnt_r != 4'h0) begin
            sense_cnt_nxt = sense_cnt_r - 4'h1;
        end
        hall_pwr_nxt = (sense_cnt_nxt != 4'h0) && (mode_nxt == WDW_STOP);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sense_cnt_r <= 4'h0;
            hall_pwr_r <= 1'b0;
        end else begin
            sense_cnt_r <= sense_cnt_nxt;
            hall_pwr_r <= hall_pwr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask, sense config and mode
    always_comb begin
        sts_nxt = sts_r;
        mask_nxt = mask_r;
        cfg_nxt = cfg_r;
        mode_nxt = mode_r;
        if (wr_sts) begin
            sts_nxt = sts_r & ~bus_req_in.wdata[1:0];
        end
        // Set wins over a simultaneous clear
        sts_nxt = sts_nxt | ev_set;
        if (wr_mask) begin
            mask_nxt = bus_req_in.wdata[1:0];
        end
        if (wr_cfg) begin
            cfg_nxt = bus_req_in.wdata;
        end
        case (mode_r)
            WDW_RUN: begin
                if (wr_sys && bus_req_in.wdata[WDW_SYS_GS]) begin
                    mode_nxt = WDW_STOP;
                end
            end
            WDW_STOP: begin
                if (pending) begin
                    mode_nxt = WDW_RUN;
                end
            end
            default: begin
                mode_nxt = WDW_RUN;
            end
        endcase
        // Interrupt pin only while stopped
        irq_nxt = in_stop && pending;
        reg_on_nxt = (mode_nxt == WDW_RUN);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sts_r <= WDW_IRQ_RST_VAL;
            mask_r <= WDW_IRQ_RST_VAL;
            cfg_r <= WDW_CFG_RST_VAL;
            mode_r <= WDW_RUN;
            irq_r <= 1'b0;
            reg_on_r <= 1'b1;
        end else begin
            sts_r <= sts_nxt;
            mask_r <= mask_nxt;
            cfg_r <= cfg_nxt;
            mode_r <= mode_nxt;
            irq_r <= irq_nxt;
            reg_on_r <= reg_on_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the read strobe
    always_comb begin
        rd_data_nxt = 8'h00;
        if (hit(bus_req_in, WDW_ADDR_CTL, 1'b1)) begin
            rd_data_nxt[WDW_CTL_RATE] = rate_r;
            rd_data_nxt[WDW_CTL_FLAG] = flag_r;
            rd_data_nxt[WDW_CTL_CC] = cc_r;
            rd_data_nxt[WDW_CTL_IE] = ie_r;
            rd_data_nxt[WDW_CTL_RE] = re_r;
            rd_data_nxt[WDW_CTL_RESTART] = 1'b0;
        end else if (hit(bus_req_in, WDW_ADDR_IRQ_STS, 1'b1)) begin
            rd_data_nxt = {6'h00, sts_r};
        end else if (hit(bus_req_in, WDW_ADDR_IRQ_MASK, 1'b1)) begin
            rd_data_nxt = {6'h00, mask_r};
        end else if (hit(bus_req_in, WDW_ADDR_SENSE_CFG, 1'b1)) begin
            rd_data_nxt = cfg_r;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign rd_data_out = rd_data_r;
    assign mcu_reset_out = mcu_reset_r;
    assign irq_out = irq_r;
    assign regulator_on_out = reg_on_r;
    assign hall_power_out = hall_pwr_r;
endmodule

/* shared/wdw_pkg.sv */
// Constants, types and register map of the watchdog with cyclic wake-up
package wdw_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] WDW_ADDR_SYS = 8'h03;
    localparam logic [7:0] WDW_ADDR_CTL = 8'h0a;
    localparam logic [7:0] WDW_ADDR_IRQ_STS = 8'h10;
    localparam logic [7:0] WDW_ADDR_IRQ_MASK = 8'h11;
    localparam logic [7:0] WDW_ADDR_SENSE_CFG = 8'h12;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of the watchdog control register
    localparam int WDW_CTL_RATE = 0;
    localparam int WDW_CTL_FLAG = 1;
    localparam int WDW_CTL_CC = 2;
    localparam int WDW_CTL_IE = 3;
    localparam int WDW_CTL_RE = 4;
    localparam int WDW_CTL_RESTART = 5;

    // Field positions of the other registers
    localparam int WDW_SYS_GS = 0;
    localparam int WDW_IRQ_TIMEOUT = 0;
    localparam int WDW_IRQ_HALL = 1;
    localparam int WDW_CFG_ANALOG = 3;
    localparam int WDW_CFG_HALL_IE = 7;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] WDW_CTL_RST_VAL = 8'h00;
    localparam logic [1:0] WDW_IRQ_RST_VAL = 2'h0;
    localparam logic [7:0] WDW_CFG_RST_VAL = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int WDW_CLK_HZ = 25000000;
    localparam int WDW_OSC_PERIOD_US = 1000;
    localparam int WDW_OSC_DIV_CYC = (WDW_CLK_HZ / 1000000) * WDW_OSC_PERIOD_US;
    localparam int WDW_FAST_MS = 10;
    localparam int WDW_SLOW_MS = 20;
    localparam int WDW_FAST_TICKS = (WDW_FAST_MS * 1000) / WDW_OSC_PERIOD_US;
    localparam int WDW_SLOW_TICKS = (WDW_SLOW_MS * 1000) / WDW_OSC_PERIOD_US;
    localparam int WDW_RST_PULSE_CYC = 16;
    localparam int WDW_SENSE_CYC = 8;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [0:0] {
        WDW_RUN = 1'b0,
        WDW_STOP = 1'b1
    } wdw_mode_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdw_bus_req_s;

endpackage

/* logic/wdw_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module wdw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import wdw_pkg::*;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic q_r;
            logic q_nxt;

            // Accept a new level once stages two and three agree
            always_comb begin
                q_nxt = (s2_r == s3_r) ? s2_r : q_r;
            end

            // Shift chain and filtered output
            always_ff @(posedge clk_sys_in) begin
                if (!rst_n_in) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    q_r <= 1'b0;
                end else begin
                    s1_r <= async_in[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    q_r <= q_nxt;
                end
            end

            assign sync_out[gi] = q_r;
        end
    endgenerate
endmodule

/* logic/wdw_tick.sv */
// Low-rate oscillator model: divider giving one tick per period
`timescale 1ns/1ps
module wdw_tick #(
    parameter int DIV = wdw_pkg::WDW_OSC_DIV_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic clr_in,
    output logic tick_out
);
    import wdw_pkg::*;

    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // Divider stops and clears while the oscillator is off
    always_comb begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!run_in || clr_in) begin
            cnt_nxt = '0;
        end else if (cnt_r == LAST) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    // Divider state
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;
endmodule

/* verification/wdw_top_properties.sv */
// Concurrent checks on the watchdog register port and output pins
`timescale 1ns/1ps
module wdw_top_properties (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire wdw_pkg::wdw_bus_req_s bus_req_in,
    input wire logic [7:0] rd_data_out,
    input wire logic mcu_reset_out,
    input wire logic irq_out,
    input wire logic regulator_on_out,
    input wire logic hall_power_out
);
    import wdw_pkg::*;

    logic ctl_wr;
    logic ctl_rd;
    logic seen_r;
    logic seen_nxt;
    logic re_r;
    logic re_nxt;

    assign ctl_wr = bus_req_in.wr && (bus_req_in.addr == WDW_ADDR_CTL);
    assign ctl_rd = bus_req_in.rd && (bus_req_in.addr == WDW_ADDR_CTL);

    ////////////////////////////////////////////////////////////////////////
    // Shadow of the write-once reset enable
    always_comb begin
        seen_nxt = seen_r | ctl_wr;
        re_nxt = re_r | (ctl_wr && !seen_r && bus_req_in.wdata[WDW_CTL_RE]);
    end

    // Shadow registers, cleared by reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            seen_r <= 1'b0;
            re_r <= 1'b0;
        end else begin
            seen_r <= seen_nxt;
            re_r <= re_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence seq_rst_hold;
        mcu_reset_out [*8];
    endsequence

    sequence seq_wake;
        $rose(regulator_on_out) ##1 (!irq_out && regulator_on_out);
    endsequence

    sequence seq_sense;
        hall_power_out [*8] ##1 !hall_power_out;
    endsequence

    AST_CTL_UPPER_ZERO: assert property (ctl_rd |=> rd_data_out[7:5] == 3'h0)
        else $error("Control read shows nonzero upper bits");
    AST_RE_STICKY: assert property (ctl_rd |=> rd_data_out[WDW_CTL_RE] == re_r)
        else $error("Reset enable readback differs from write-once shadow");
    AST_NO_RST_WITHOUT_RE: assert property ($rose(mcu_reset_out) |-> re_r)
        else $error("Reset output rose without reset enable");
    AST_RST_PULSE: assert property ($rose(mcu_reset_out) |-> seq_rst_hold ##1 seq_rst_hold ##1 !mcu_reset_out)
        else $error("Reset pulse length wrong");
    AST_RST_ONLY_RUN: assert property (mcu_reset_out |-> regulator_on_out)
        else $error("Reset output high in low power mode");
    AST_IRQ_WAKE: assert property ($rose(irq_out) |-> seq_wake)
        else $error("Interrupt not tied to wake-up");
    AST_SENSE_WINDOW: assert property ($rose(hall_power_out) |-> seq_sense)
        else $error("Sensor power window length wrong");
    AST_SENSE_ONLY_STOP: assert property (hall_power_out |-> !regulator_on_out)
        else $error("Sensor power in run mode");
    AST_RESET_STATE: assert property ($rose(rst_n_in) |-> rd_data_out == 8'h00 && !mcu_reset_out
        && !irq_out && regulator_on_out && !hall_power_out)
        else $error("Outputs not at reset values");
endmodule

bind wdw_top wdw_top_properties u_props (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .bus_req_in(bus_req_in),
    .rd_data_out(rd_data_out),
    .mcu_reset_out(mcu_reset_out),
    .irq_out(irq_out),
    .regulator_on_out(regulator_on_out),
    .hall_power_out(hall_power_out)
);

/* verification/wdw_mcu_model.sv */
// Microcontroller side: counts resets and interrupts it receives
`timescale 1ns/1ps
module wdw_mcu_model (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic mcu_reset_in,
    input wire logic irq_in,
    output logic [7:0] rst_seen_out,
    output logic [7:0] irq_seen_out,
    output logic [7:0] rst_len_out
);
    logic [7:0] len_r;
    logic rst_q_r;
    logic irq_q_r;

    // Edge counting on both lines, reset pulse length measured
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rst_seen_out <= 8'h00;
            irq_seen_out <= 8'h00;
            rst_len_out <= 8'h00;
            len_r <= 8'h00;
            rst_q_r <= 1'b0;
            irq_q_r <= 1'b0;
        end else begin
            rst_q_r <= mcu_reset_in;
            irq_q_r <= irq_in;
            if (mcu_reset_in && !rst_q_r) begin
                rst_seen_out <= rst_seen_out + 8'h01;
            end
            if (irq_in && !irq_q_r) begin
                irq_seen_out <= irq_seen_out + 8'h01;
            end
            len_r <= mcu_reset_in ? len_r + 8'h01 : 8'h00;
            if (!mcu_reset_in && rst_q_r) begin
                rst_len_out <= len_r;
            end
        end
    end
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the watchdog with cyclic wake-up
`timescale 1ns/1ps
module tb_top;
    import wdw_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } wdw_row_s;

    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    wdw_bus_req_s bus_req = '0;
    logic [2:0] hall = 3'h0;
    logic analog = 1'b0;
    logic [7:0] rd_data;
    logic mcu_reset;
    logic irq;
    logic reg_on;
    logic hall_pwr;
    logic [7:0] rst_seen;
    logic [7:0] irq_seen;
    logic [7:0] rst_len;
    logic [7:0] hp_cnt = 8'h00;
    int n_fail = 0;
    int tests_run = 0;
    wdw_row_s rows [5];

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and far-side model
    always #20 clk_sys_in = ~clk_sys_in;

    always @(posedge hall_pwr) hp_cnt++;

    wdw_top #(.OSC_DIV(4), .FAST_TICKS(2), .SLOW_TICKS(4), .NUM_HALL(3)) uut (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .bus_req_in(bus_req),
        .hall_in(hall),
        .analog_in(analog),
        .rd_data_out(rd_data),
        .mcu_reset_out(mcu_reset),
        .irq_out(irq),
        .regulator_on_out(reg_on),
        .hall_power_out(hall_pwr)
    );

    wdw_mcu_model u_mcu (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .mcu_reset_in(mcu_reset),
        .irq_in(irq),
        .rst_seen_out(rst_seen),
        .irq_seen_out(irq_seen),
        .rst_len_out(rst_len)
    );

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        bus_req <= '0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        bus_req <= '0;
        @(negedge clk_sys_in);
        chk(rd_data, exp);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_fail++;
        $display("Watchdog span expired");
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rows[0] = '{WDW_ADDR_SENSE_CFG, 8'h8f, 8'h8f};
        rows[1] = '{WDW_ADDR_IRQ_MASK, 8'hff, 8'h03};
        rows[2] = '{WDW_ADDR_IRQ_STS, 8'h03, 8'h00};
        rows[3] = '{WDW_ADDR_SYS, 8'h00, 8'h00};
        rows[4] = '{8'h55, 8'hff, 8'h00};
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].exp);
        end
        $display("Register table done");
        // Idle watchdog with no enables never flags
        cyc(60);
        rdchk(WDW_ADDR_CTL, 8'h00);
        // Reset enable refused after first write, rates and flag
        wr(WDW_ADDR_CTL, 8'h09);
        wr(WDW_ADDR_CTL, 8'h39);
        rdchk(WDW_ADDR_CTL, 8'h09);
        cyc(8);
        rdchk(WDW_ADDR_CTL, 8'h0b);
        wr(WDW_ADDR_CTL, 8'h09);
        rdchk(WDW_ADDR_CTL, 8'h0b);
        wr(WDW_ADDR_CTL, 8'h0b);
        rdchk(WDW_ADDR_CTL, 8'h09);
        wr(WDW_ADDR_CTL, 8'h0a);
        cyc(9);
        rdchk(WDW_ADDR_CTL, 8'h08);
        cyc(5);
        rdchk(WDW_ADDR_CTL, 8'h0a);
        chk(rst_seen, 8'h00);
        chk(irq_seen, 8'h00);
        $display("Timeout flag done");
        // Periodic interrupt: masked first, then released
        wr(WDW_ADDR_CTL, 8'h0b);
        wr(WDW_ADDR_IRQ_MASK, 8'h00);
        wr(WDW_ADDR_SYS, 8'h01);
        cyc(1);
        chk({7'h00, reg_on}, 8'h00);
        cyc(30);
        chk(irq_seen, 8'h00);
        rdchk(WDW_ADDR_IRQ_STS, 8'h01);
        wr(WDW_ADDR_IRQ_MASK, 8'h01);
        cyc(3);
        chk(irq_seen, 8'h01);
        chk({7'h00, reg_on}, 8'h01);
        wr(WDW_ADDR_IRQ_STS, 8'h01);
        rdchk(WDW_ADDR_IRQ_STS, 8'h00);
        rdchk(WDW_ADDR_SYS, 8'h00);
        wr(WDW_ADDR_CTL, 8'h0b);
        wr(WDW_ADDR_SYS, 8'h01);
        cyc(20);
        chk(irq_seen, 8'h02);
        $display("Periodic interrupt done");
        // Cyclic check: unselected inputs high, then selected one
        wr(WDW_ADDR_IRQ_MASK, 8'h02);
        wr(WDW_ADDR_SENSE_CFG, 8'h81);
        // Slow rate, so each sense window closes before the next period
        wr(WDW_ADDR_CTL, 8'h04);
        wr(WDW_ADDR_IRQ_STS, 8'h03);
        @(posedge clk_sys_in);
        hall <= 3'h6;
        wr(WDW_ADDR_SYS, 8'h01);
        cyc(40);
        chk(irq_seen, 8'h02);
        chk({7'h00, hp_cnt != 8'h00}, 8'h01);
        @(posedge clk_sys_in);
        hall <= 3'h1;
        cyc(30);
        chk(irq_seen, 8'h03);
        rdchk(WDW_ADDR_IRQ_STS, 8'h02);
        // Analog input alone wakes the system
        wr(WDW_ADDR_SENSE_CFG, 8'h88);
        wr(WDW_ADDR_IRQ_STS, 8'h03);
        analog <= 1'b1;
        wr(WDW_ADDR_SYS, 8'h01);
        cyc(30);
        chk(irq_seen, 8'h04);
        $display("Cyclic check done");
        // Second reset in mid-run, then the reset function
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        hall <= 3'h0;
        cyc(4);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        foreach (rows[i]) begin
            rdchk(i == 4 ? WDW_ADDR_CTL : rows[i].addr, 8'h00);
        end
        wr(WDW_ADDR_CTL, 8'h39);
        wr(WDW_ADDR_CTL, 8'h29);
        rdchk(WDW_ADDR_CTL, 8'h19);
        repeat (10) wr(WDW_ADDR_CTL, 8'h39);
        chk(rst_seen, 8'h00);
        wr(WDW_ADDR_IRQ_MASK, 8'h01);
        wr(WDW_ADDR_CTL, 8'h39);
        wr(WDW_ADDR_SYS, 8'h01);
        cyc(12);
        chk(irq_seen, 8'h01);
        chk(rst_seen, 8'h00);
        cyc(3);
        chk({7'h00, mcu_reset}, 8'h01);
        // Keep restarting so no later timeout stretches the pulse
        repeat (9) wr(WDW_ADDR_CTL, 8'h39);
        cyc(1);
        chk({7'h00, mcu_reset}, 8'h00);
        chk(rst_seen, 8'h01);
        chk(rst_len, 8'h10);
        $display("Reset function done");
        complete_run();
    end
endmodule
